// ==== kwd_pkg.sv ====
package kwd_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_WDT_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_RST_CAUSE   = 8'h04;
    localparam logic [7:0] ADDR_CORE_STAT   = 8'h08;
    localparam logic [7:0] ADDR_CORE_CMD    = 8'h0c;
    localparam logic [7:0] ADDR_RSTPIN_FUNC = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h18;

    // Control register fields and reset values
    localparam int         KEY_MSB          = 7;
    localparam int         KEY_LSB          = 3;
    localparam int         SEL_MSB          = 2;
    localparam logic [4:0] KEY_DISABLE      = 5'h15;
    localparam logic [4:0] KEY_ENABLE       = 5'h0a;
    localparam logic [7:0] WDT_CTRL_RESET   = 8'h53;
    localparam logic [7:0] RSTPIN_FUNC_IO   = 8'h55;
    localparam logic [7:0] RSTPIN_FUNC_PIN  = 8'haa;

    // Reset cause bit positions
    localparam int         KEYRST_BIT       = 0;

    // Core status bit positions
    localparam int         TIMEOUT_BIT      = 0;
    localparam int         PDOWN_BIT        = 1;

    // Command register bits: write one to issue
    localparam int         CMD_CLEAR_BIT    = 0;
    localparam int         CMD_HALT_BIT     = 1;
    localparam int         CMD_WAKE_BIT     = 2;

    // Interrupt event bits
    localparam int         EV_TIMEOUT       = 0;
    localparam int         EV_KEYRST        = 1;
    localparam int         EV_WAKE          = 2;
    localparam int         EV_WIDTH         = 3;

    // Timing
    localparam int         CLK_HZ           = 100_000_000;
    localparam int         SLOW_OSC_HZ      = 32_000;
    localparam int         SW_RESET_DELAY_US = 100;
    localparam int         SW_RESET_CYCLES  = SW_RESET_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int         RESET_PULSE_CYCLES = 4;

    localparam logic [1:0] RESP_OKAY        = 2'b00;
    localparam logic [1:0] RESP_SLVERR      = 2'b10;

    typedef struct packed {
        logic resetReq;
        logic pcSpReset;
        logic wake;
    } kwd_core_req_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_DOWN  = 3'b010,
        ST_RESET = 3'b100
    } kwd_state_t;

endpackage

// ==== kwd_keyed_watchdog_timer.sv ====
`timescale 1ns/10ps
module kwd_keyed_watchdog_timer #(
    parameter int SW_RESET_CYCLES = kwd_pkg::SW_RESET_CYCLES,
    parameter int OSC_HZ          = kwd_pkg::SLOW_OSC_HZ
) (
    input  wire logic        mclk,            // System clock, 100 MHz
    input  wire logic        rstn,            // Power-on reset, sync, active low
    input  wire logic        slowOscClock,    // Slow oscillator, asynchronous
    input  wire logic        extResetPinN,    // External reset pin, asynchronous
    input  wire logic [7:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [7:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready,    // Read data ready
    output kwd_pkg::kwd_core_req_t coreReq,   // Reset and wake requests to core
    output logic             irq              // Level interrupt
);

    // ==================================================
    // Input synchronisers
    logic [2:0] oscSync;
    logic [1:0] pinSync;
    logic       oscTick;
    logic       pinLow;

    always_ff @(posedge mclk) begin
        oscSync <= {oscSync[1:0], slowOscClock};
        pinSync <= {pinSync[0], extResetPinN};
    end

    assign oscTick = oscSync[1] & ~oscSync[2];
    assign pinLow  = ~pinSync[1];

    // ==================================================
    // Bus handshake
    logic wrFire;
    logic rdFire;
    logic wrSel;
    logic [31:0] wdata;

    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wrFire        = s_axi_awready;
    assign rdFire        = s_axi_arvalid & s_axi_arready;
    assign wdata         = s_axi_wdata;
    assign wrSel         = wrFire & s_axi_wstrb[0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[7:2] <= kwd_pkg::ADDR_IRQ_MASK[7:2];
    endfunction

    // ==================================================
    // Watchdog state
    logic [7:0]           wdtCtrl,      next_wdtCtrl;
    logic [7:0]           rstPinFunc,   next_rstPinFunc;
    logic                 keyRstFlag,   next_keyRstFlag;
    logic                 timeoutFlag,  next_timeoutFlag;
    logic                 pdownFlag,    next_pdownFlag;
    logic [17:0]          wdtCount,     next_wdtCount;
    logic [31:0]          delayCount,   next_delayCount;
    logic [2:0]           pulseCount,   next_pulseCount;
    kwd_pkg::kwd_state_t  state,        next_state;
    kwd_pkg::kwd_core_req_t next_coreReq;
    logic [kwd_pkg::EV_WIDTH-1:0] irqStatus, next_irqStatus;
    logic [kwd_pkg::EV_WIDTH-1:0] irqMask,   next_irqMask;
    logic [31:0]          next_rdata;
    logic [1:0]           next_rresp;
    logic [1:0]           next_bresp;

    logic [4:0]  key;
    logic        keyValid;
    logic        enabled;
    logic [17:0] limit;
    logic        overflow;
    logic        cmdClear;
    logic        cmdHalt;
    logic        cmdWake;
    logic        pinReset;
    logic [kwd_pkg::EV_WIDTH-1:0] events;

    assign key      = wdtCtrl[kwd_pkg::KEY_MSB:kwd_pkg::KEY_LSB];
    assign enabled  = key == kwd_pkg::KEY_ENABLE;
    assign keyValid = enabled | (key == kwd_pkg::KEY_DISABLE);
    assign cmdClear = wrSel & hit(s_axi_awaddr, kwd_pkg::ADDR_CORE_CMD) & wdata[kwd_pkg::CMD_CLEAR_BIT];
    assign cmdHalt  = wrSel & hit(s_axi_awaddr, kwd_pkg::ADDR_CORE_CMD) & wdata[kwd_pkg::CMD_HALT_BIT];
    assign cmdWake  = wrSel & hit(s_axi_awaddr, kwd_pkg::ADDR_CORE_CMD) & wdata[kwd_pkg::CMD_WAKE_BIT];
    assign pinReset = pinLow & (rstPinFunc == kwd_pkg::RSTPIN_FUNC_PIN);

    // zero-based terminal count (period minus one) of the selected period
    always_comb begin
        unique case (wdtCtrl[kwd_pkg::SEL_MSB:0])
            3'h0:    limit = 18'h000ff;
            3'h1:    limit = 18'h003ff;
            3'h2:    limit = 18'h00fff;
            3'h3:    limit = 18'h03fff;
            3'h4:    limit = 18'h07fff;
            3'h5:    limit = 18'h0ffff;
            3'h6:    limit = 18'h1ffff;
            default: limit = 18'h3ffff;
        endcase
    end

    assign overflow = enabled & oscTick & (wdtCount == limit) & (state != kwd_pkg::ST_RESET);

    always_comb begin
        next_wdtCtrl     = wdtCtrl;
        next_rstPinFunc  = rstPinFunc;
        next_keyRstFlag  = keyRstFlag;
        next_timeoutFlag = timeoutFlag;
        next_pdownFlag   = pdownFlag;
        next_wdtCount    = wdtCount;
        next_delayCount  = delayCount;
        next_pulseCount  = pulseCount;
        next_state       = state;
        next_coreReq     = '0;
        next_irqMask     = irqMask;
        events           = '0;

        if (wrSel && hit(s_axi_awaddr, kwd_pkg::ADDR_WDT_CTRL)) begin
            next_wdtCtrl = wdata[7:0];
        end
        if (wrSel && hit(s_axi_awaddr, kwd_pkg::ADDR_RSTPIN_FUNC)) begin
            next_rstPinFunc = wdata[7:0];
        end
        if (wrSel && hit(s_axi_awaddr, kwd_pkg::ADDR_IRQ_MASK)) begin
            next_irqMask = wdata[kwd_pkg::EV_WIDTH-1:0];
        end
        if (wrSel && hit(s_axi_awaddr, kwd_pkg::ADDR_RST_CAUSE) && !wdata[kwd_pkg::KEYRST_BIT]) begin
            next_keyRstFlag = 1'b0;
        end

        // Counter: advance on slow ticks while enabled
        if (enabled && oscTick) begin
            next_wdtCount = wdtCount + 18'h1;
        end
        if (cmdClear) begin
            next_pdownFlag = 1'b0;
        end
        if (cmdHalt) begin
            next_pdownFlag   = 1'b1;
            next_timeoutFlag = 1'b0;
            next_state       = kwd_pkg::ST_DOWN;
        end
        if (cmdWake && state == kwd_pkg::ST_DOWN) begin
            next_state = kwd_pkg::ST_RUN;
        end

        // Invalid key: count up the software reset delay
        if (!keyValid) begin
            if (delayCount == 32'(SW_RESET_CYCLES - 1)) begin
                next_delayCount = '0;
                next_keyRstFlag = 1'b1;
                events[kwd_pkg::EV_KEYRST] = 1'b1;
                next_state      = kwd_pkg::ST_RESET;
                next_pulseCount = '0;
            end else begin
                next_delayCount = delayCount + 32'h1;
            end
        end else begin
            next_delayCount = '0;
        end

        if (overflow) begin
            next_timeoutFlag = 1'b1;
            events[kwd_pkg::EV_TIMEOUT] = 1'b1;
            if (state == kwd_pkg::ST_DOWN) begin
                next_coreReq.wake      = 1'b1;
                next_coreReq.pcSpReset = 1'b1;
                next_state             = kwd_pkg::ST_RUN;
                events[kwd_pkg::EV_WAKE] = 1'b1;
            end else begin
                next_state      = kwd_pkg::ST_RESET;
                next_pulseCount = '0;
            end
        end

        // Full reset from pin; wakes too if powered down
        if (pinReset) begin
            next_state      = kwd_pkg::ST_RESET;
            next_pulseCount = '0;
            if (state == kwd_pkg::ST_DOWN) begin
                next_coreReq.wake = 1'b1;
            end
        end

        if (state == kwd_pkg::ST_RESET) begin
            next_coreReq.resetReq = 1'b1;
            // Pulse length counts from the pin's release
            next_pulseCount = pinReset ? 3'h0 : pulseCount + 3'h1;
            if (pulseCount == 3'(kwd_pkg::RESET_PULSE_CYCLES - 1) && !pinReset) begin
                next_state       = kwd_pkg::ST_RUN;
                next_wdtCtrl     = kwd_pkg::WDT_CTRL_RESET;
                next_rstPinFunc  = kwd_pkg::RSTPIN_FUNC_IO;
                next_pdownFlag   = 1'b0;
            end
        end

        // Every clear restarts the full period
        if (!keyValid || cmdClear || cmdHalt || pinReset || overflow ||
            state == kwd_pkg::ST_RESET) begin
            next_wdtCount = '0;
        end
    end

    // ==================================================
    // Interrupt status: set wins over write-one clear
    always_comb begin
        next_irqStatus = irqStatus;
        if (wrSel && hit(s_axi_awaddr, kwd_pkg::ADDR_IRQ_STATUS)) begin
            next_irqStatus = irqStatus & ~wdata[kwd_pkg::EV_WIDTH-1:0];
        end
        next_irqStatus = next_irqStatus | events;
    end

    // ==================================================
    // Read data and responses
    always_comb begin
        next_rdata = '0;
        next_rresp = kwd_pkg::RESP_OKAY;
        if (hit(s_axi_araddr, kwd_pkg::ADDR_WDT_CTRL)) begin
            next_rdata[7:0] = wdtCtrl;
        end else if (hit(s_axi_araddr, kwd_pkg::ADDR_RST_CAUSE)) begin
            next_rdata[kwd_pkg::KEYRST_BIT] = keyRstFlag;
        end else if (hit(s_axi_araddr, kwd_pkg::ADDR_CORE_STAT)) begin
            next_rdata[kwd_pkg::TIMEOUT_BIT] = timeoutFlag;
            next_rdata[kwd_pkg::PDOWN_BIT]   = pdownFlag;
        end else if (hit(s_axi_araddr, kwd_pkg::ADDR_RSTPIN_FUNC)) begin
            next_rdata[7:0] = rstPinFunc;
        end else if (hit(s_axi_araddr, kwd_pkg::ADDR_IRQ_STATUS)) begin
            next_rdata[kwd_pkg::EV_WIDTH-1:0] = irqStatus;
        end else if (hit(s_axi_araddr, kwd_pkg::ADDR_IRQ_MASK)) begin
            next_rdata[kwd_pkg::EV_WIDTH-1:0] = irqMask;
        end else if (!mapped(s_axi_araddr)) begin
            next_rresp = kwd_pkg::RESP_SLVERR;
        end
        next_bresp = mapped(s_axi_awaddr) ? kwd_pkg::RESP_OKAY : kwd_pkg::RESP_SLVERR;
    end

    assign irq = |(irqStatus & irqMask);

    // ==================================================
    // Registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wdtCtrl      <= kwd_pkg::WDT_CTRL_RESET;
            rstPinFunc   <= kwd_pkg::RSTPIN_FUNC_IO;
            keyRstFlag   <= 1'b0;
            timeoutFlag  <= 1'b0;
            pdownFlag    <= 1'b0;
            wdtCount     <= '0;
            delayCount   <= '0;
            pulseCount   <= '0;
            state        <= kwd_pkg::ST_RUN;
            coreReq      <= '0;
            irqStatus    <= '0;
            irqMask      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= kwd_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= kwd_pkg::RESP_OKAY;
        end else begin
            wdtCtrl      <= next_wdtCtrl;
            rstPinFunc   <= next_rstPinFunc;
            keyRstFlag   <= next_keyRstFlag;
            timeoutFlag  <= next_timeoutFlag;
            pdownFlag    <= next_pdownFlag;
            wdtCount     <= next_wdtCount;
            delayCount   <= next_delayCount;
            pulseCount   <= next_pulseCount;
            state        <= next_state;
            coreReq      <= next_coreReq;
            irqStatus    <= next_irqStatus;
            irqMask      <= next_irqMask;
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= next_bresp;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rresp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ==== kwd_watchdog_properties.sv ====
`timescale 1ns/10ps
module kwd_watchdog_properties (
    input wire logic                   mclk,          // Clock
    input wire logic                   rstn,          // Reset, active low
    input wire logic                   s_axi_awvalid, // Write address valid
    input wire logic                   s_axi_wvalid,  // Write data valid
    input wire logic                   s_axi_bvalid,  // Write response valid
    input wire logic                   s_axi_bready,  // Write response ready
    input wire logic                   s_axi_arvalid, // Read address valid
    input wire logic                   s_axi_rvalid,  // Read data valid
    input wire logic                   s_axi_rready,  // Read data ready
    input wire kwd_pkg::kwd_core_req_t coreReq,       // Core requests
    input wire logic                   irq            // Interrupt
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // ==========================================
    // Bus answers
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write not answered in one cycle");
    a_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    // ==========================================
    // Core requests
    a_reset_pulse_len: assert property ($rose(coreReq.resetReq) |-> coreReq.resetReq [*4])
        else $error("device reset shorter than four cycles");
    a_wake_one_cycle: assert property (coreReq.wake |=> !coreReq.wake)
        else $error("wake pulse too long");
    a_pcsp_only_wake: assert property (coreReq.pcSpReset |-> coreReq.wake && !coreReq.resetReq)
        else $error("pc reset without wake or with device reset");
    a_quiet_start: assert property ($rose(rstn) |-> !irq && !coreReq.resetReq && !coreReq.wake)
        else $error("activity right after power-on");
endmodule
bind kwd_keyed_watchdog_timer kwd_watchdog_properties u_props (.mclk, .rstn, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .coreReq, .irq);

// ==== kwd_core_model.sv ====
`timescale 1ns/10ps
module kwd_core_model (
    input  wire logic                   mclk,         // System clock
    input  wire kwd_pkg::kwd_core_req_t coreReq,      // Requests from the watchdog
    output logic                        slowOscClock  // Slow oscillator
);
    logic lastReset = 1'b0;
    int   resetCnt  = 0;
    int   wakeCnt   = 0;
    int   pcSpCnt   = 0;
    initial slowOscClock = 1'b0;
    // ==========================================
    // Counts what the core is asked to do
    always @(posedge mclk) begin
        lastReset <= coreReq.resetReq;
        if (coreReq.resetReq && !lastReset) resetCnt <= resetCnt + 1;
        if (coreReq.wake) wakeCnt <= wakeCnt + 1;
        if (coreReq.pcSpReset) pcSpCnt <= pcSpCnt + 1;
    end
    // Oscillator bursts, eight system clocks per cycle (four high, four low); still between bursts
    task automatic tick(input int n);
        repeat (n) begin
            slowOscClock <= 1'b1;
            repeat (4) @(posedge mclk);
            slowOscClock <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
endmodule

// ==== tb_kwd_keyed_watchdog_timer.sv ====
`timescale 1ns/10ps
module tb_kwd_keyed_watchdog_timer;
    logic                   mclk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   extResetPinN = 1'b1;
    logic [7:0]             awAddr = 8'h00;
    logic [31:0]            wData = 32'h0;
    logic                   awValid = 1'b0;
    logic                   wValid = 1'b0;
    logic                   bReady = 1'b0;
    logic [7:0]             arAddr = 8'h00;
    logic                   arValid = 1'b0;
    logic                   rReady = 1'b0;
    logic                   slowOscClock, awReady, wReady, bValid, arReady, rValid, irq;
    logic [1:0]             bResp, rResp, resp;
    logic [31:0]            rData, rd;
    kwd_pkg::kwd_core_req_t coreReq;
    int                     errorCnt = 0;
    int                     testsRun = 0;
    int                     expRst = 0;

    always #5 mclk = ~mclk;

    kwd_keyed_watchdog_timer #(.SW_RESET_CYCLES(8)) dut (
        .mclk(mclk), .rstn(rstn), .slowOscClock(slowOscClock), .extResetPinN(extResetPinN),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .coreReq(coreReq), .irq(irq)
    );
    kwd_core_model core (.mclk(mclk), .coreReq(coreReq), .slowOscClock(slowOscClock));

    // ==========================================
    // Bus tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do @(posedge mclk); while (!(awReady && wReady));
        awValid <= 1'b0;
        wValid <= 1'b0;
        do @(posedge mclk); while (!bValid);
        resp = bResp;
        bReady <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge mclk); while (!arReady);
        arValid <= 1'b0;
        do @(posedge mclk); while (!rValid);
        rd = rData;
        resp = rResp;
        rReady <= 1'b0;
        @(posedge mclk);
        check(rd, exp);
    endtask
    task automatic run(input int n);
        core.tick(n);
        repeat (20) @(posedge mclk);
    endtask
    task automatic completeRun;
        if (errorCnt == 0 && testsRun > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Test sequence
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rdChk(kwd_pkg::ADDR_WDT_CTRL, 32'h53);
        rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h0);
        wr(kwd_pkg::ADDR_CORE_STAT, 32'h3);
        check({30'h0, resp}, {30'h0, kwd_pkg::RESP_OKAY});
        rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h0);
        rdChk(kwd_pkg::ADDR_RST_CAUSE, 32'h0);
        wr(8'h1c, 32'h1);
        check({30'h0, resp}, {30'h0, kwd_pkg::RESP_SLVERR});
        rdChk(8'h1c, 32'h0);
        check({30'h0, resp}, {30'h0, kwd_pkg::RESP_SLVERR});
        for (int s = 0; s < 8; s++) begin
            wr(kwd_pkg::ADDR_WDT_CTRL, {24'h0, kwd_pkg::KEY_DISABLE, s[2:0]});
            rdChk(kwd_pkg::ADDR_WDT_CTRL, {24'h0, 5'h15, s[2:0]});
        end
        for (int s = 0; s < 3; s++) begin
            wr(kwd_pkg::ADDR_WDT_CTRL, {24'h0, kwd_pkg::KEY_ENABLE, s[2:0]});
            wr(kwd_pkg::ADDR_CORE_CMD, 32'h1);
            repeat (400) @(posedge mclk);
            run((1 << (8 + 2 * s)) - 1);
            check(core.resetCnt, expRst);
            run(1);
            expRst++;
            check(core.resetCnt, expRst);
            rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h1);
        end
        wr(kwd_pkg::ADDR_WDT_CTRL, 32'ha8);
        run(300);
        check(core.resetCnt, expRst);
        wr(kwd_pkg::ADDR_WDT_CTRL, 32'h50);
        wr(kwd_pkg::ADDR_CORE_CMD, 32'h1);
        run(200);
        wr(kwd_pkg::ADDR_CORE_CMD, 32'h1);
        run(200);
        check(core.resetCnt, expRst);
        wr(kwd_pkg::ADDR_CORE_CMD, 32'h2);
        rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h2);
        run(255);
        check(core.wakeCnt, 0);
        run(1);
        check(core.wakeCnt, 1);
        check(core.pcSpCnt, 1);
        check(core.resetCnt, expRst);
        rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h3);
        wr(kwd_pkg::ADDR_CORE_CMD, 32'h1);
        rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h1);
        // Wake by another source: a later overflow resets instead of waking
        wr(kwd_pkg::ADDR_CORE_CMD, 32'h2);
        wr(kwd_pkg::ADDR_CORE_CMD, 32'h4);
        run(256);
        expRst++;
        check(core.resetCnt, expRst);
        check(core.wakeCnt, 1);
        rdChk(kwd_pkg::ADDR_CORE_STAT, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(kwd_pkg::ADDR_WDT_CTRL, 32'hfb);
        repeat (30) @(posedge mclk);
        expRst++;
        check(core.resetCnt, expRst);
        rdChk(kwd_pkg::ADDR_RST_CAUSE, 32'h1);
        wr(kwd_pkg::ADDR_RST_CAUSE, 32'h1);
        rdChk(kwd_pkg::ADDR_RST_CAUSE, 32'h1);
        wr(kwd_pkg::ADDR_RST_CAUSE, 32'h0);
        rdChk(kwd_pkg::ADDR_RST_CAUSE, 32'h0);
        rdChk(kwd_pkg::ADDR_IRQ_STATUS, 32'h7);
        wr(kwd_pkg::ADDR_IRQ_MASK, 32'h2);
        check({31'h0, irq}, 32'h1);
        wr(kwd_pkg::ADDR_IRQ_STATUS, 32'h2);
        check({31'h0, irq}, 32'h0);
        rdChk(kwd_pkg::ADDR_IRQ_STATUS, 32'h5);
        wr(kwd_pkg::ADDR_RSTPIN_FUNC, 32'haa);
        extResetPinN <= 1'b0;
        repeat (10) @(posedge mclk);
        extResetPinN <= 1'b1;
        repeat (20) @(posedge mclk);
        expRst++;
        check(core.resetCnt, expRst);
        completeRun;
    end

    initial begin
        repeat (90000) @(posedge mclk);
        errorCnt++;
        completeRun;
    end
endmodule
